// ===== logic/power_switch_pkg.sv
// Constants shared by the power switch command decoder and its link logic.
// Assumes 8-bit command frames and a 25 MHz system clock.
`default_nettype none

package power_switch_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 8;
  localparam int CH_COUNT = 6;
  localparam int WRITE_BIT = 7;
  localparam int BANK_BIT = 6;
  localparam int ADDR_HI = 5;
  localparam int ADDR_LO = 4;
  localparam int DATA_HI = 3;
  localparam int DIAG_REQ_BIT = 0;

  // ----------------------------------------------------------------
  // Configuration bank addresses
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_PULSE = 2'h1;
  localparam logic [1:0] ADDR_HARDWARE = 2'h2;
  localparam logic [1:0] ADDR_DIAG_CTRL = 2'h3;

  // ----------------------------------------------------------------
  // Field positions inside the configuration registers
  // ----------------------------------------------------------------
  localparam int HW_CTL_BIT = 0;
  localparam int HW_RST_BIT = 1;
  localparam int HW_STB_BIT = 1;
  localparam int DCR_SBM_BIT = 3;
  localparam int DCR_MUX_HI = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] CHANNEL_RESET = 6'h00;
  localparam logic [3:0] PULSE_RESET = 4'h0;
  localparam logic HW_CTL_RESET = 1'b0;
  localparam logic [2:0] DCR_MUX_RESET = 3'h7;
  localparam logic TER_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Link counters
  // ----------------------------------------------------------------
  localparam int RISE_W = 4;
  localparam logic [3:0] RISE_SAT = 4'h8;
  localparam logic [3:0] RISE_FIRST = 4'h1;
  localparam logic [2:0] FALL_FIRST = 3'h1;
  localparam logic [2:0] FALL_WHOLE = 3'h0;
  localparam int SYNC_W = 14;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FRAME,
    ST_COMMIT
  } frame_state_type;

endpackage : power_switch_pkg

`default_nettype wire

// ===== logic/bit_sync.sv
// Two-stage synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level or a gray-coded / quasi-static value.
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : bit_sync

`default_nettype wire

// ===== logic/serial_link_shifter.sv
// Serial-clock domain of the decoder: shifts in data, counts edges.
// Assumes chip select is high between frames and the master runs the
// serial clock only while chip select is low.
`default_nettype none

module serial_link_shifter (
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  output logic [3:0] rise_gray_out,
  output logic [7:0] rx_byte_out,
  output logic [2:0] fall_mod_out,
  output logic frame_toggle_out
);

  logic link_clear_n;
  logic [3:0] rise_cnt_q;
  logic [3:0] rise_cnt_d;
  logic [3:0] rise_gray_q;
  logic [3:0] rise_gray_d;
  logic [7:0] rx_q;
  logic [7:0] rx_d;
  logic [2:0] fall_mod_q;
  logic [2:0] fall_mod_d;
  logic tog_q;
  logic tog_d;
  logic first_fall;

  // Idle chip select holds the rise counter at zero between frames
  assign link_clear_n = rst_n_in & ~cs_n_in;

  // ----------------------------------------------------------------
  // Rising edges: output bit index, gray coded for the crossing
  // ----------------------------------------------------------------
  always_comb begin
    rise_cnt_d = rise_cnt_q;
    if (rise_cnt_q != power_switch_pkg::RISE_SAT) begin
      rise_cnt_d = rise_cnt_q + 4'h1;
    end
    rise_gray_d = rise_cnt_d ^ (rise_cnt_d >> 1);
  end

  always_ff @(posedge sclk_in or negedge link_clear_n) begin
    if (!link_clear_n) begin
      rise_cnt_q <= 4'h0;
      rise_gray_q <= 4'h0;
    end else begin
      rise_cnt_q <= rise_cnt_d;
      rise_gray_q <= rise_gray_d;
    end
  end

  // ----------------------------------------------------------------
  // Falling edges: sample data in, count clocks modulo eight
  // ----------------------------------------------------------------
  always_comb begin
    first_fall = (rise_cnt_q == power_switch_pkg::RISE_FIRST);
    rx_d = {rx_q[6:0], si_in};
    tog_d = first_fall ? ~tog_q : tog_q;
    fall_mod_d = first_fall ? power_switch_pkg::FALL_FIRST
                            : fall_mod_q + 3'h1;
  end

  always_ff @(negedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_q <= 8'h00;
      fall_mod_q <= 3'h0;
      tog_q <= 1'b0;
    end else begin
      rx_q <= rx_d;
      fall_mod_q <= fall_mod_d;
      tog_q <= tog_d;
    end
  end

  assign rise_gray_out = rise_gray_q;
  assign rx_byte_out = rx_q;
  assign fall_mod_out = fall_mod_q;
  assign frame_toggle_out = tog_q;

endmodule : serial_link_shifter

`default_nettype wire

// ===== logic/power_switch_spi_frame_decoder.sv
// Command decoder of a six-channel high-side switch behind a serial port.
// Assumes an external master on sclk/cs_n/si/so and a 25 MHz system clock;
// the power stage and protection sit outside and use the outputs here.
//
// Contract
// - Bit 6 picks the bank: channel register or configuration registers.
// - Write channels: bit 7 set, bit 6 clear, bits 5..0 new states.
// - Channel bit 1 turns that channel on, 0 off; six channels.
// - Configuration bank: bits 5:4 address the register acted on.
// - Configuration write data in bits 3:0; reads return it there.
// - Read request: bit 7 clear, bit 0 clear; bit 0 set asks diagnosis.
// - A read takes two frames; answer comes in the following frame.
// - Read answer: bit 7 set, bit 6 bank, then channels or addr+data.
// - A command in the answering frame is still decoded and executed.
// - Error flag reads 0 after a frame with a multiple of eight clocks.
// - Error flag reads 1 after a bad clock count and after reset.
// - Error flag is on data out before the first rising clock edge.
// - Diagnosis: bit 7 clear, bit 6 fallback pin, bits 5..0 faults.
// - Fallback bit follows the fallback-mode pin level.
// - Reset: channels 0x00, pulse 0x00, hardware 0x02, diagnosis 0x07.
// - Data sampled at falling clock edges; clock at most 2 MHz.
`default_nettype none

module power_switch_spi_frame_decoder (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic fallback_mode_pin_in,
  input wire logic [5:0] channel_fault_flag_in,
  input wire logic switch_bypass_monitor_in,
  output logic so_out,
  output logic so_oe_n_out,
  output logic [5:0] channel_on_bit_out,
  output logic [3:0] pulse_config_out,
  output logic control_select_out,
  output logic [2:0] sense_select_out,
  output logic standby_state_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Gray count from the serial domain back to binary
  function automatic logic [3:0] gray_to_bin(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray_to_bin

  function automatic logic [1:0] cmd_addr(input logic [7:0] cmd);
    return cmd[power_switch_pkg::ADDR_HI:power_switch_pkg::ADDR_LO];
  endfunction : cmd_addr

  function automatic logic [3:0] cmd_data(input logic [7:0] cmd);
    return cmd[power_switch_pkg::DATA_HI:0];
  endfunction : cmd_data

  // ----------------------------------------------------------------
  // Serial clock domain
  // ----------------------------------------------------------------
  logic [3:0] rise_gray;
  logic [7:0] rx_byte;
  logic [2:0] fall_mod;
  logic frame_toggle;

  serial_link_shifter u_link (
    .rst_n_in(rst_n_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .si_in(si_in),
    .rise_gray_out(rise_gray),
    .rx_byte_out(rx_byte),
    .fall_mod_out(fall_mod),
    .frame_toggle_out(frame_toggle)
  );

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  // rx_byte and fall_mod are not synchronised bit by bit: they are only
  // read after chip select has been seen high through the synchroniser,
  // when no serial edge can move them.
  logic [power_switch_pkg::SYNC_W-1:0] sync_raw;
  logic [power_switch_pkg::SYNC_W-1:0] sync_val;
  logic cs_n_s;
  logic tog_s;
  logic [3:0] gray_s;
  logic fallback_s;
  logic [5:0] fault_s;
  logic bypass_s;

  // Chip select enters inverted: the synchroniser resets to 0, which has
  // to read as deselected, or data out would be driven after reset
  assign sync_raw = {~cs_n_in, frame_toggle, rise_gray, fallback_mode_pin_in,
                     channel_fault_flag_in, switch_bypass_monitor_in};

  bit_sync #(
    .WIDTH(power_switch_pkg::SYNC_W)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(sync_raw),
    .sync_out(sync_val)
  );

  // Positions inside the synchronised bundle
  localparam int SY_CS = 13;
  localparam int SY_TOG = 12;
  localparam int SY_GRAY_HI = 11;
  localparam int SY_GRAY_LO = 8;
  localparam int SY_FALLBACK = 7;
  localparam int SY_FAULT_HI = 6;
  localparam int SY_FAULT_LO = 1;
  localparam int SY_BYPASS = 0;

  assign cs_n_s = ~sync_val[SY_CS];
  assign tog_s = sync_val[SY_TOG];
  assign gray_s = sync_val[SY_GRAY_HI:SY_GRAY_LO];
  assign fallback_s = sync_val[SY_FALLBACK];
  assign fault_s = sync_val[SY_FAULT_HI:SY_FAULT_LO];
  assign bypass_s = sync_val[SY_BYPASS];

  // ----------------------------------------------------------------
  // Frame sequencer and register file
  // ----------------------------------------------------------------
  power_switch_pkg::frame_state_type state_q;
  power_switch_pkg::frame_state_type state_d;

  // Register file
  logic [5:0] channel_q;
  logic [5:0] channel_d;
  logic [3:0] pulse_q;
  logic [3:0] pulse_d;
  logic hw_ctl_q;
  logic hw_ctl_d;
  logic [2:0] mux_q;
  logic [2:0] mux_d;

  // Answer path
  logic ter_q;
  logic ter_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;

  // Frame bookkeeping and standby status
  logic seen_tog_q;
  logic seen_tog_d;
  logic standby_q;
  logic standby_d;

  // Reset values of the answer path and status
  localparam logic [7:0] TX_RESET = 8'h00;
  localparam logic SEEN_TOG_RESET = 1'b0;
  localparam logic STANDBY_RESET = 1'b1;

  logic clk_ok;
  logic is_write;
  logic is_cfg;
  logic [3:0] hw_read;
  logic [3:0] dcr_read;
  logic [3:0] cfg_read;
  logic [7:0] diag_word;

  // ----------------------------------------------------------------
  // Command decode, meaningful only once chip select is seen high
  // ----------------------------------------------------------------
  always_comb begin
    clk_ok = (tog_s != seen_tog_q) &&
             (fall_mod == power_switch_pkg::FALL_WHOLE);
    is_write = rx_byte[power_switch_pkg::WRITE_BIT];
    is_cfg = rx_byte[power_switch_pkg::BANK_BIT];
    // Bits 3 and 2 of the hardware register read 0
    hw_read = 4'h0;
    hw_read[power_switch_pkg::HW_STB_BIT] = standby_q;
    hw_read[power_switch_pkg::HW_CTL_BIT] = hw_ctl_q;
    // Bit 3 shows the bypass monitor; a write to it is dropped
    dcr_read = {bypass_s, mux_q};
    case (cmd_addr(rx_byte))
      power_switch_pkg::ADDR_PULSE: cfg_read = pulse_q;
      power_switch_pkg::ADDR_HARDWARE: cfg_read = hw_read;
      power_switch_pkg::ADDR_DIAG_CTRL: cfg_read = dcr_read;
      default: cfg_read = 4'h0;
    endcase
    diag_word = {1'b0, fallback_s, fault_s};
  end

  // ----------------------------------------------------------------
  // Next values of the sequencer and the register file
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    channel_d = channel_q;
    pulse_d = pulse_q;
    hw_ctl_d = hw_ctl_q;
    mux_d = mux_q;
    ter_d = ter_q;
    tx_d = tx_q;
    seen_tog_d = seen_tog_q;
    // Standby trails the channel register by one clock
    standby_d = (channel_q == power_switch_pkg::CHANNEL_RESET);

    case (state_q)
      power_switch_pkg::ST_IDLE: begin
        if (!cs_n_s) begin
          state_d = power_switch_pkg::ST_FRAME;
        end
      end
      power_switch_pkg::ST_FRAME: begin
        if (cs_n_s) begin
          state_d = power_switch_pkg::ST_COMMIT;
        end
      end
      power_switch_pkg::ST_COMMIT: begin
        state_d = power_switch_pkg::ST_IDLE;
        seen_tog_d = tog_s;
        ter_d = ~clk_ok;
        // Default answer when no read is pending
        tx_d = diag_word;

        // A cut frame moves only the flag and the answer (diagnosis word), never a register
        if (clk_ok) begin
          if (is_write && !is_cfg) begin
            channel_d = rx_byte[power_switch_pkg::CH_COUNT-1:0];
          end else if (is_write) begin
            case (cmd_addr(rx_byte))
              power_switch_pkg::ADDR_PULSE: begin
                pulse_d = cmd_data(rx_byte);
              end
              power_switch_pkg::ADDR_HARDWARE: begin
                hw_ctl_d = rx_byte[power_switch_pkg::HW_CTL_BIT];
                // Software reset restores all register defaults
                if (rx_byte[power_switch_pkg::HW_RST_BIT]) begin
                  channel_d = power_switch_pkg::CHANNEL_RESET;
                  pulse_d = power_switch_pkg::PULSE_RESET;
                  hw_ctl_d = power_switch_pkg::HW_CTL_RESET;
                  mux_d = power_switch_pkg::DCR_MUX_RESET;
                end
              end
              power_switch_pkg::ADDR_DIAG_CTRL: begin
                mux_d = rx_byte[power_switch_pkg::DCR_MUX_HI:0];
              end
              default: begin
                channel_d = channel_q;
              end
            endcase
          end else if (!rx_byte[power_switch_pkg::DIAG_REQ_BIT]) begin
            // Read request, bit 0 clear: answered next frame
            if (is_cfg) begin
              tx_d = {1'b1, 1'b1, cmd_addr(rx_byte), cfg_read};
            end else begin
              tx_d = {1'b1, 1'b0, channel_q};
            end
          end
          // Bit 0 set on a read asks the diagnosis word, the default
        end
      end
      default: begin
        state_d = power_switch_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= power_switch_pkg::ST_IDLE;
      channel_q <= power_switch_pkg::CHANNEL_RESET;
      pulse_q <= power_switch_pkg::PULSE_RESET;
      hw_ctl_q <= power_switch_pkg::HW_CTL_RESET;
      mux_q <= power_switch_pkg::DCR_MUX_RESET;
      ter_q <= power_switch_pkg::TER_RESET;
      tx_q <= TX_RESET;
      seen_tog_q <= SEEN_TOG_RESET;
      standby_q <= STANDBY_RESET;
    end else begin
      state_q <= state_d;
      channel_q <= channel_d;
      pulse_q <= pulse_d;
      hw_ctl_q <= hw_ctl_d;
      mux_q <= mux_d;
      ter_q <= ter_d;
      tx_q <= tx_d;
      seen_tog_q <= seen_tog_d;
      standby_q <= standby_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial data out
  // ----------------------------------------------------------------
  // Index follows the synchronised rising-edge count, about three system
  // clocks late: well inside one serial half period at 2 MHz or less.
  logic so_q;
  logic so_d;
  logic so_oe_n_q;
  logic so_oe_n_d;
  logic [3:0] rise_idx;
  logic [3:0] bit_pos;

  always_comb begin
    rise_idx = gray_to_bin(gray_s);
    bit_pos = power_switch_pkg::RISE_SAT - rise_idx;
    // Low enable drives the pin, only while selected
    so_oe_n_d = cs_n_s;
    so_d = so_q;
    if (!cs_n_s) begin
      if (rise_idx == 4'h0) begin
        so_d = ter_q;
      end else begin
        // Past eight rises the index saturates and bit 0 stands
        so_d = tx_q[bit_pos[2:0]];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else begin
      so_q <= so_d;
      so_oe_n_q <= so_oe_n_d;
    end
  end

  // Every output comes straight from a flop
  assign so_out = so_q;
  assign so_oe_n_out = so_oe_n_q;
  assign channel_on_bit_out = channel_q;
  assign pulse_config_out = pulse_q;
  assign control_select_out = hw_ctl_q;
  assign sense_select_out = mux_q;
  assign standby_state_out = standby_q;

endmodule : power_switch_spi_frame_decoder

`default_nettype wire

// ===== dv/power_switch_chk.sv
// Concurrent checks on the pins of the power switch command decoder.
// Assumes it is bound to the decoder top; system clock domain only.
`default_nettype none

module power_switch_chk (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic fallback_mode_pin_in,
  input wire logic [5:0] channel_fault_flag_in,
  input wire logic switch_bypass_monitor_in,
  input wire logic so_out,
  input wire logic so_oe_n_out,
  input wire logic [5:0] channel_on_bit_out,
  input wire logic [3:0] pulse_config_out,
  input wire logic control_select_out,
  input wire logic [2:0] sense_select_out,
  input wire logic standby_state_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // First frame tracker: set by reset, cleared at first serial rise
  // ----------------------------------------------------------------
  logic first_q;
  logic first_d;

  always_comb begin
    first_d = first_q & ~(~cs_n_in & sclk_in);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_q <= 1'b1;
    end else begin
      first_q <= first_d;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_reset_values: assert property ($past(rst_n_in) == 1'b0 |->
    channel_on_bit_out == 6'h00 && pulse_config_out == 4'h0 &&
    !control_select_out && sense_select_out == 3'h7)
    else $error("register outputs differ from reset values");
  chk_standby_map: assert property (1'b1 |=>
    standby_state_out == ($past(channel_on_bit_out) == 6'h00))
    else $error("standby does not follow all channels off");
  chk_channel_commit: assert property (
    !$stable(channel_on_bit_out) |-> cs_n_in)
    else $error("channel outputs changed inside a frame");
  chk_config_commit: assert property (!$stable(
    {pulse_config_out, control_select_out, sense_select_out}) |-> cs_n_in)
    else $error("configuration outputs changed inside a frame");
  chk_oe_release: assert property (
    $rose(cs_n_in) |-> ##[1:4] so_oe_n_out)
    else $error("data out not released after chip select rose");
  chk_oe_drive: assert property (
    $fell(cs_n_in) |-> ##[1:4] !so_oe_n_out)
    else $error("data out not driven after chip select fell");
  chk_oe_idle: assert property (
    cs_n_in [*4] |-> so_oe_n_out)
    else $error("data out driven while deselected");
  chk_ter_first: assert property (
    (first_q && !cs_n_in) [*5] |-> so_out)
    else $error("error flag low in first frame after reset");

endmodule : power_switch_chk

bind power_switch_spi_frame_decoder power_switch_chk u_chk (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .sclk_in(sclk_in),
  .cs_n_in(cs_n_in),
  .si_in(si_in),
  .fallback_mode_pin_in(fallback_mode_pin_in),
  .channel_fault_flag_in(channel_fault_flag_in),
  .switch_bypass_monitor_in(switch_bypass_monitor_in),
  .so_out(so_out),
  .so_oe_n_out(so_oe_n_out),
  .channel_on_bit_out(channel_on_bit_out),
  .pulse_config_out(pulse_config_out),
  .control_select_out(control_select_out),
  .sense_select_out(sense_select_out),
  .standby_state_out(standby_state_out)
);

`default_nettype wire

// ===== dv/spi_master_model.sv
// Behavioural serial master driving chip select, clock and data in.
// Assumes the bench calls xfer; the serial clock stands low between frames.
`default_nettype none

module spi_master_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame of n clocks, most significant bit first
  // ----------------------------------------------------------------
  // Period 520 ns keeps under 2 MHz, exactly thirteen periods of the 40 ns clock
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic transmission_error_flag, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    cs_n_out = 1'b0;
    #1200; // Lead time before first rise
    transmission_error_flag = so_in; // Flag before first rise
    for (i = n - 1; i >= 0; i--) begin
      si_out = (i < 8) ? tx[i] : 1'b0;
      #20;
      sclk_out = 1'b1;
      #260;
      rx = {rx[6:0], so_in}; // Sampled at falling edge
      sclk_out = 1'b0;
      #240;
    end
    // Released data line falls to its pull-down level
    si_out = 1'b0;
    #1000;
    cs_n_out = 1'b1;
    #1200; // Gap between frames
  endtask : xfer

endmodule : spi_master_model

`default_nettype wire

// ===== dv/power_switch_spi_frame_decoder_bench.sv
// Self-checking bench for the power switch command decoder.
// Assumes the serial master model and the bound checker are compiled.
`default_nettype none

module power_switch_spi_frame_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LIMIT = 10000;

  logic clk_in;
  logic rst_n_in;
  logic sclk_in;
  logic cs_n_in;
  logic si_in;
  logic fallback_mode_pin_in;
  logic [5:0] channel_fault_flag_in;
  logic switch_bypass_monitor_in;
  logic so_out;
  logic so_oe_n_out;
  logic [5:0] channel_on_bit_out;
  logic [3:0] pulse_config_out;
  logic control_select_out;
  logic [2:0] sense_select_out;
  logic standby_state_out;
  logic so_line;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  power_switch_spi_frame_decoder DUT (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .si_in(si_in),
    .fallback_mode_pin_in(fallback_mode_pin_in),
    .channel_fault_flag_in(channel_fault_flag_in),
    .switch_bypass_monitor_in(switch_bypass_monitor_in),
    .so_out(so_out),
    .so_oe_n_out(so_oe_n_out),
    .channel_on_bit_out(channel_on_bit_out),
    .pulse_config_out(pulse_config_out),
    .control_select_out(control_select_out),
    .sense_select_out(sense_select_out),
    .standby_state_out(standby_state_out)
  );

  // A released data line shows the inverse, so a late enable is caught
  assign so_line = so_oe_n_out ? ~so_out : so_out;

  spi_master_model master (
    .sclk_out(sclk_in),
    .cs_n_out(cs_n_in),
    .si_out(si_in),
    .so_in(so_line)
  );

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Comparison, frame and closing tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic frame(input logic [7:0] tx, input int n, input logic et,
                       input logic [7:0] er, input bit cr);
    logic transmission_error_flag;
    logic [7:0] rx;
    master.xfer(tx, n, transmission_error_flag, rx);
    check("error flag", {7'h00, transmission_error_flag}, {7'h00, et});
    if (cr) begin
      check("answer", rx, er);
    end
  endtask : frame

  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    fallback_mode_pin_in = 1'b1;
    channel_fault_flag_in = 6'h2C;
    switch_bypass_monitor_in = 1'b1;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check("channels", {2'h0, channel_on_bit_out}, 8'h00);
    check("pulse", {4'h0, pulse_config_out}, 8'h00);
    check("control", {7'h00, control_select_out}, 8'h00);
    check("sense", {5'h00, sense_select_out}, 8'h07);
    check("standby", {7'h00, standby_state_out}, 8'h01);
    check("enable", {7'h00, so_oe_n_out}, 8'h01);
    frame(8'h00, 8, 1'b1, 8'h00, 1'b0);
    frame(8'hA5, 8, 1'b0, 8'h80, 1'b1);
    check("channels", {2'h0, channel_on_bit_out}, 8'h25);
    check("standby", {7'h00, standby_state_out}, 8'h00);
    frame(8'h50, 8, 1'b0, 8'h6C, 1'b1);
    frame(8'hDA, 8, 1'b0, 8'hD0, 1'b1);
    check("pulse", {4'h0, pulse_config_out}, 8'h0A);
    frame(8'h60, 8, 1'b0, 8'h6C, 1'b1);
    frame(8'hF3, 8, 1'b0, 8'hE0, 1'b1);
    check("sense", {5'h00, sense_select_out}, 8'h03);
    @(posedge clk_in);
    fallback_mode_pin_in <= 1'b0;
    frame(8'h80, 7, 1'b0, 8'h00, 1'b0);
    check("channels", {2'h0, channel_on_bit_out}, 8'h25);
    frame(8'h01, 8, 1'b1, 8'h2C, 1'b1);
    frame(8'h70, 8, 1'b0, 8'h2C, 1'b1);
    frame(8'h80, 8, 1'b0, 8'hFB, 1'b1);
    check("channels", {2'h0, channel_on_bit_out}, 8'h00);
    check("standby", {7'h00, standby_state_out}, 8'h01);
    frame(8'hE1, 8, 1'b0, 8'h2C, 1'b1);
    check("control", {7'h00, control_select_out}, 8'h01);
    frame(8'hE2, 8, 1'b0, 8'h2C, 1'b1);
    check("pulse", {4'h0, pulse_config_out}, 8'h00);
    check("sense", {5'h00, sense_select_out}, 8'h07);
    check("control", {7'h00, control_select_out}, 8'h00);
    frame(8'h60, 8, 1'b0, 8'h2C, 1'b1);
    frame(8'h01, 8, 1'b0, 8'hE2, 1'b1);
    close_out();
  end

endmodule : power_switch_spi_frame_decoder_bench

`default_nettype wire
